// File: logic/ccr_csr_top.sv
// Purpose: Control and status register slave on the backplane configuration space.
// Assumes: All backplane pins are asynchronous; two flops precede any logic.
// Notes:   Answers only inside the top sixteen bytes of the selected region.
//          Reset mode is only reported; the board decides what it stops doing.
module ccr_csr_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Backplane slave pins, active-low strobes.
  input  wire logic [23:1] i_addr,
  input  wire logic [5:0]  i_am,
  input  wire logic        i_as_n,
  input  wire logic        i_ds0_n,
  input  wire logic        i_ds1_n,
  input  wire logic        i_write_n,
  input  wire logic        i_lword_n,
  input  wire logic [7:0]  i_data,
  output logic      [7:0]  o_data,
  output logic             o_data_oe,
  output logic             o_dtack_n,
  output logic             o_dtack_oe,
  // Open-drain system-fail line.
  output logic             o_sysfail_n,
  output logic             o_sysfail_oe,
  // Board side.
  input  wire logic        i_board_failed,
  output logic             o_reset_mode,
  output logic             o_sysfail_en,
  output logic      [7:0]  o_region_sel
);

  // IDLE waits for a decode, XFER touches the registers, DRIVE puts read data
  // on the bus and HOLD acknowledges until the master lets go of the strobes.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_XFER  = 2'b01,
    ST_DRIVE = 2'b10,
    ST_HOLD  = 2'b11
  } ccr_state_e;

  logic [23:1]      addr_s;
  logic [4:0]       strb_s;
  logic [5:0]       am_s;
  logic             as_n_s;
  logic             ds0_n_s;
  logic             ds1_n_s;
  logic             write_n_s;
  logic             lword_n_s;
  logic [7:0]       data_s;

  ccr_state_e       state_r;
  ccr_state_e       state_nxt;
  logic [18:0]      ofs;
  logic [18:0]      ofs_r;
  logic             wr_r;
  logic             hit;
  logic             strobe_on;
  logic             am_ok;
  logic             region_ok;
  logic             region_legal;
  logic             window_ok;
  logic             acc;
  logic [7:0]       rdata;
  logic [7:0]       bar;
  logic             rst_mode;
  logic             sfe;

  // Region field of a region-select byte; the decode reads it twice.
  function automatic logic [4:0] region_of(input logic [7:0] sel_byte);
    region_of = sel_byte[ccr_pkg::BAR_HI:ccr_pkg::BAR_LO];
  endfunction

  // Each pin group has its own synchroniser. All of them reset to the idle high
  // level so that releasing reset never looks like a falling strobe.
  ccr_sync #(
    .WIDTH     (23),
    .RST_VAL   (23'h7FFFFF)
  ) u_sync_addr (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_addr),
    .o_sync    (addr_s)
  );

  ccr_sync #(
    .WIDTH     (6),
    .RST_VAL   (6'h3F)
  ) u_sync_am (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_am),
    .o_sync    (am_s)
  );

  ccr_sync #(
    .WIDTH     (5),
    .RST_VAL   (5'h1F)
  ) u_sync_strb (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_as_n, i_ds0_n, i_ds1_n, i_write_n, i_lword_n}),
    .o_sync    (strb_s)
  );

  ccr_sync #(
    .WIDTH     (8),
    .RST_VAL   (8'hFF)
  ) u_sync_data (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_data),
    .o_sync    (data_s)
  );

  assign {as_n_s, ds0_n_s, ds1_n_s, write_n_s, lword_n_s} = strb_s;

  // A lone even-byte strobe lands on an even offset, which is always reserved.
  assign ofs       = {addr_s[18:1], ~ds0_n_s};
  assign strobe_on = !as_n_s && (!ds0_n_s || !ds1_n_s);

  // Reset mode is deliberately absent here so the bus keeps answering in it.
  // Long-word cycles are not served: only single bytes reach these registers.
  assign am_ok        = lword_n_s && (am_s == ccr_pkg::AM_CSR);
  assign region_ok    = addr_s[23:19] == region_of(bar);
  // A region-select of zero would collide with slot identification, so the
  // board then stays silent until it is reset.
  assign region_legal = region_of(bar) != 5'h00;
  // Only the top sixteen bytes answer; everything below is the ROM area.
  assign window_ok    = ofs[18:ccr_pkg::WIN_LSB] == ccr_pkg::WIN_BASE[18:ccr_pkg::WIN_LSB];
  assign hit          = strobe_on && am_ok && region_ok && region_legal && window_ok;

  // The machine waits in HOLD until the address strobe or both data strobes are released, so a strobe
  // that is still held can never start a second access.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (hit) state_nxt = ST_XFER;
      ST_XFER:  state_nxt = ST_DRIVE;
      ST_DRIVE: state_nxt = ST_HOLD;
      ST_HOLD:  if (o_dtack_oe && !strobe_on) state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Offset and direction are frozen at the decode so a late pin change cannot
  // retarget an access already under way.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ofs_r <= 19'h00000;
    else if (state_r == ST_IDLE && hit)
      ofs_r <= ofs;
  end

  // A write is recognised by the direction pin as it stood at the decode.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wr_r <= 1'b0;
    else if (state_r == ST_IDLE && hit)
      wr_r <= !write_n_s;
  end

  // Exactly one register access per bus cycle, one edge after the decode.
  assign acc = (state_r == ST_XFER);

  // The core holds the three defined registers; nothing else in the window
  // stores data.
  ccr_reg_core u_core (
    .i_sys_clk      (i_sys_clk),
    .i_rst_n        (i_rst_n),
    .i_acc          (acc),
    .i_wr           (wr_r),
    .i_ofs          (ofs_r),
    .i_wdata        (data_s),
    .i_board_failed (i_board_failed),
    .o_rdata        (rdata),
    .o_bar          (bar),
    .o_reset_mode   (rst_mode),
    .o_sysfail_en   (sfe)
  );

  // Read data go onto the bus one cycle before the acknowledge so they are
  // settled when the master samples them.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_data <= 8'h00;
    else if (state_r == ST_DRIVE)
      o_data <= rdata;
    else if (state_nxt == ST_IDLE)
      o_data <= 8'h00;
  end

  // The data drivers open only on reads; a write cycle never drives the lines.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_data_oe <= 1'b0;
    else if (state_r == ST_DRIVE)
      o_data_oe <= !wr_r;
    else if (state_nxt == ST_IDLE)
      o_data_oe <= 1'b0;
  end

  // The acknowledge is raised once per cycle and held until the release.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_dtack_oe <= 1'b0;
    else if (state_r == ST_HOLD && !o_dtack_oe)
      o_dtack_oe <= 1'b1;
    else if (state_nxt == ST_IDLE)
      o_dtack_oe <= 1'b0;
  end

  // Open-drain lines only ever pull low.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_dtack_n <= 1'b0;
    else
      o_dtack_n <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sysfail_n <= 1'b0;
    else
      o_sysfail_n <= 1'b0;
  end

  // The fail line is pulled only when the board has failed and the driver is on.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sysfail_oe <= 1'b0;
    else
      o_sysfail_oe <= sfe && i_board_failed;
  end

  // Board-side copies trail the internal bits by one cycle so that every
  // output comes straight from a flop.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reset_mode <= ccr_pkg::RST_MODE_RST;
    else
      o_reset_mode <= rst_mode;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sysfail_en <= ccr_pkg::SFE_RST;
    else
      o_sysfail_en <= sfe;
  end

  // Software reads the whole stored byte back, low bits included.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_region_sel <= ccr_pkg::BAR_RST;
    else
      o_region_sel <= bar;
  end

endmodule // ccr_csr_top

// File: logic/ccr_pkg.sv
// Purpose: Shared constants for the control and status register block.
// Assumes: Configuration-space accesses use 24-bit addressing on the backplane.
// Notes:   Offsets are byte offsets inside a board's 512 KB configuration region.
package ccr_pkg;

  // Address modifier of a configuration-space access.
  localparam logic [5:0]  AM_CSR      = 6'h2F;

  // Register byte offsets inside the region.
  localparam logic [18:0] OFS_CLR     = 19'h7FFF7;
  localparam logic [18:0] OFS_SET     = 19'h7FFFB;
  localparam logic [18:0] OFS_BAR     = 19'h7FFFF;

  // The top sixteen bytes form the register window.
  localparam logic [18:0] WIN_BASE    = 19'h7FFF0;
  localparam int          WIN_LSB     = 4;

  // Field positions of the set and clear registers.
  localparam int          BIT_RST     = 7;
  localparam int          BIT_SFE     = 6;
  localparam int          BIT_FAIL    = 5;

  // Region field of the region-select register.
  localparam int          BAR_HI      = 7;
  localparam int          BAR_LO      = 3;

  // Reset values.
  localparam logic [7:0]  BAR_RST     = 8'h08;
  localparam logic        RST_MODE_RST = 1'b0;
  localparam logic        SFE_RST     = 1'b0;

  // Register select codes.
  localparam logic [1:0]  SEL_NONE    = 2'h0;
  localparam logic [1:0]  SEL_CLR     = 2'h1;
  localparam logic [1:0]  SEL_SET     = 2'h2;
  localparam logic [1:0]  SEL_BAR     = 2'h3;

  // Pin synchroniser depth.
  localparam int          SYNC_STAGES = 2;

endpackage : ccr_pkg

// File: logic/ccr_sync.sv
// Purpose: Multi-bit two-flop synchroniser for backplane pins.
// Assumes: Each bit is sampled independently; buses are stable while strobed.
// Notes:   Only the last stage is visible outside this module.
module ccr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // Both stages reset to the idle level of the pin, so releasing reset never
  // looks like a falling strobe.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_sys_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_r[g] <= RST_VAL[g];
          o_sync[g] <= RST_VAL[g];
        end
        else
        begin
          meta_r[g] <= i_async[g];
          o_sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule // ccr_sync

// File: logic/ccr_reg_core.sv
// Purpose: Region-select, set and clear registers with their side effects.
// Assumes: One access strobe per bus cycle, from the access sequencer.
// Notes:   Read data are registered on the access strobe.
module ccr_reg_core (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_acc,
  input  wire logic        i_wr,
  input  wire logic [18:0] i_ofs,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_board_failed,
  output logic      [7:0]  o_rdata,
  output logic      [7:0]  o_bar,
  output logic             o_reset_mode,
  output logic             o_sysfail_en
);

  logic [1:0] sel;
  logic [7:0] status;

  function automatic logic [1:0] reg_sel(input logic [18:0] ofs);
    unique case (ofs)
      ccr_pkg::OFS_CLR: reg_sel = ccr_pkg::SEL_CLR;
      ccr_pkg::OFS_SET: reg_sel = ccr_pkg::SEL_SET;
      ccr_pkg::OFS_BAR: reg_sel = ccr_pkg::SEL_BAR;
      default:          reg_sel = ccr_pkg::SEL_NONE;
    endcase
  endfunction

  assign sel = reg_sel(i_ofs);

  // Both status registers show the same live state.
  always_comb
  begin
    status                    = 8'h00;
    status[ccr_pkg::BIT_RST]  = o_reset_mode;
    status[ccr_pkg::BIT_SFE]  = o_sysfail_en;
    status[ccr_pkg::BIT_FAIL] = i_board_failed;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_bar <= ccr_pkg::BAR_RST;
    else if (i_acc && i_wr && sel == ccr_pkg::SEL_BAR)
      o_bar <= i_wdata;
  end

  // Bit five is never written from the bus.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reset_mode <= ccr_pkg::RST_MODE_RST;
    else if (i_acc && i_wr && sel == ccr_pkg::SEL_SET && i_wdata[ccr_pkg::BIT_RST])
      o_reset_mode <= 1'b1;
    else if (i_acc && i_wr && sel == ccr_pkg::SEL_CLR && i_wdata[ccr_pkg::BIT_RST])
      o_reset_mode <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_sysfail_en <= ccr_pkg::SFE_RST;
    else if (i_acc && i_wr && sel == ccr_pkg::SEL_SET && i_wdata[ccr_pkg::BIT_SFE])
      o_sysfail_en <= 1'b1;
    else if (i_acc && i_wr && sel == ccr_pkg::SEL_CLR && i_wdata[ccr_pkg::BIT_SFE])
      o_sysfail_en <= 1'b0;
  end

  // Reserved window bytes read as zero and swallow writes.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (i_acc)
    begin
      unique case (sel)
        ccr_pkg::SEL_CLR,
        ccr_pkg::SEL_SET:  o_rdata <= status;
        ccr_pkg::SEL_BAR:  o_rdata <= o_bar;
        ccr_pkg::SEL_NONE: o_rdata <= 8'h00;
      endcase
    end
  end

endmodule // ccr_reg_core

// File: dv/ccr_csr_chk.sv
// Purpose: Port-level checks of the control and status register slave.
// Assumes: Pins sit two flops from the logic; helper pipes line up with that.
// Notes:   Old register state is taken six edges back, before the write lands.
module ccr_csr_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [23:1] i_addr,
  input wire logic [5:0]  i_am,
  input wire logic        i_as_n,
  input wire logic        i_ds0_n,
  input wire logic        i_ds1_n,
  input wire logic        i_write_n,
  input wire logic        i_lword_n,
  input wire logic [7:0]  i_data,
  input wire logic        i_board_failed,
  input wire logic [7:0]  o_data,
  input wire logic        o_data_oe,
  input wire logic        o_dtack_oe,
  input wire logic        o_sysfail_n,
  input wire logic        o_sysfail_oe,
  input wire logic        o_reset_mode,
  input wire logic        o_sysfail_en,
  input wire logic [7:0]  o_region_sel
);
  logic [18:0] a1, a2;
  logic [7:0]  d1, d2;
  logic [4:0]  r1, r2;
  logic        w1, w2, k1, k2, dq, eq;
  always_ff @(posedge i_sys_clk)
  begin
    a1 <= {i_addr[18:1], ~i_ds0_n};
    a2 <= a1;
    d1 <= i_data;
    d2 <= d1;
    r1 <= i_addr[23:19];
    r2 <= r1;
    w1 <= !i_write_n;
    w2 <= w1;
    k1 <= !i_as_n && i_lword_n && i_am == ccr_pkg::AM_CSR;
    k2 <= k1;
    dq <= o_dtack_oe;
    eq <= o_data_oe;
  end
  wire rs = o_dtack_oe && !dq;
  wire es = o_data_oe && !eq;
  wire st = a2 == ccr_pkg::OFS_SET || a2 == ccr_pkg::OFS_CLR;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_take;
    rs && !(w2 && a2 == ccr_pkg::OFS_BAR) |-> k2 && r2 == o_region_sel[7:3] && r2 != 5'h00
      && a2[18:4] == 15'h7FFF;
  endproperty
  a_take: assert property (p_take) else $error("acknowledge outside own window");
  property p_set;
    rs && w2 && a2 == ccr_pkg::OFS_SET |-> o_reset_mode == (d2[7] || $past(o_reset_mode, 6))
      && o_sysfail_en == (d2[6] || $past(o_sysfail_en, 6));
  endproperty
  a_set: assert property (p_set) else $error("set write result wrong");
  property p_clr;
    rs && w2 && a2 == ccr_pkg::OFS_CLR |-> o_reset_mode == (!d2[7] && $past(o_reset_mode, 6))
      && o_sysfail_en == (!d2[6] && $past(o_sysfail_en, 6));
  endproperty
  a_clr: assert property (p_clr) else $error("clear write result wrong");
  property p_bar;
    rs && w2 && a2 == ccr_pkg::OFS_BAR |-> o_region_sel == d2;
  endproperty
  a_bar: assert property (p_bar) else $error("region select not stored");
  property p_rdst;
    es && st |-> o_data[7:6] == {o_reset_mode, o_sysfail_en} && o_data[4:0] == 5'h00;
  endproperty
  a_rdst: assert property (p_rdst) else $error("status read wrong");
  property p_rsvd;
    es && !st && a2 != ccr_pkg::OFS_BAR |-> o_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
  property p_rel;
    dq && !o_dtack_oe |-> $past(i_as_n, 2) || ($past(i_ds0_n, 2) && $past(i_ds1_n, 2));
  endproperty
  a_rel: assert property (p_rel) else $error("acknowledge dropped under strobes");
  property p_rdack;
    rs && !w2 |-> $past(o_data_oe) && o_data_oe;
  endproperty
  a_rdack: assert property (p_rdack) else $error("read acknowledged without data");
  property p_fail;
    o_sysfail_oe == (o_sysfail_en && $past(i_board_failed)) && !o_sysfail_n;
  endproperty
  a_fail: assert property (p_fail) else $error("fail line drive wrong");
endmodule // ccr_csr_chk
bind ccr_csr_top ccr_csr_chk ccr_csr_chk_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_am(i_am), .i_as_n(i_as_n), .i_ds0_n(i_ds0_n), .i_ds1_n(i_ds1_n),
  .i_write_n(i_write_n), .i_lword_n(i_lword_n), .i_data(i_data), .o_data(o_data),
  .i_board_failed(i_board_failed), .o_data_oe(o_data_oe), .o_dtack_oe(o_dtack_oe),
  .o_sysfail_n(o_sysfail_n), .o_sysfail_oe(o_sysfail_oe), .o_reset_mode(o_reset_mode),
  .o_sysfail_en(o_sysfail_en), .o_region_sel(o_region_sel));

// File: dv/ccr_bm.sv
// Purpose: Backplane master running single-byte configuration-space cycles.
// Assumes: Pins change on the falling edge; strobes hold until acknowledge is seen or sixteen rising edges pass without one.
// Notes:   Released data and address lines show the inverse of their last value.
module ccr_bm (
  input  wire logic        i_sys_clk,
  input  wire logic        i_dtack_oe,
  input  wire logic [7:0]  i_data,
  output logic      [23:1] o_addr,
  output logic      [5:0]  o_am,
  output logic             o_as_n,
  output logic             o_ds0_n,
  output logic             o_ds1_n,
  output logic             o_write_n,
  output logic             o_lword_n,
  output logic      [7:0]  o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {o_addr, o_am, o_data} = '0;
    {o_as_n, o_ds0_n, o_ds1_n, o_write_n, o_lword_n} = 5'h1F;
  end
  // Callers pass region fields from zero to thirty-one; zero probes the illegal region.
  task automatic acc(input logic [23:0] adr, input logic wr, input logic [5:0] am,
                     input logic [7:0] wd, output logic [7:0] rd, output logic ack);
    int n;
    @(negedge i_sys_clk);
    o_addr    = adr[23:1];
    o_am      = am;
    o_write_n = !wr;
    o_ds0_n   = !adr[0];
    o_ds1_n   = adr[0];
    o_data    = wr ? wd : ~o_data;
    o_as_n    = 1'b0;
    ack       = 1'b0;
    for (n = 0; n < 16 && !ack; n++)
    begin
      @(posedge i_sys_clk);
      ack = i_dtack_oe;
    end
    rd = i_data;
    @(negedge i_sys_clk);
    {o_as_n, o_ds0_n, o_ds1_n} = 3'h7;
    o_data = ~o_data;
    for (n = 0; n < 8 && i_dtack_oe; n++)
      @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    o_addr = ~o_addr;
    o_am   = ~o_am;
  endtask
endmodule // ccr_bm

// File: dv/tb_top.sv
// Purpose: Self-checking bench of the control and status register slave.
// Assumes: Board region one after reset; fail input driven on falling edges.
// Notes:   Every scenario task except t_reset_vals and t_zero reads back what it wrote through the bus.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_sys_clk, i_rst_n, i_board_failed;
  logic [23:1] addr;
  logic [5:0]  am;
  logic [7:0]  wdat, rdat, sel, rd, bus_d;
  logic        as_n, ds0_n, ds1_n, write_n, lword_n, oe, ack_oe, dt_n, sf_n, sf_oe, rm, sfe, ack;
  int          fail_count = 0;
  int          n_compared = 0;
  ccr_csr_top ccr_csr_top_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_am(am), .i_as_n(as_n), .i_ds0_n(ds0_n), .i_ds1_n(ds1_n), .i_write_n(write_n),
    .i_lword_n(lword_n), .i_data(wdat), .o_data(rdat), .o_data_oe(oe), .o_dtack_n(dt_n),
    .o_dtack_oe(ack_oe), .o_sysfail_n(sf_n), .o_sysfail_oe(sf_oe), .o_reset_mode(rm),
    .i_board_failed(i_board_failed), .o_sysfail_en(sfe), .o_region_sel(sel));
  ccr_bm ccr_bm_inst (.i_sys_clk(i_sys_clk), .i_dtack_oe(ack_oe), .i_data(bus_d),
    .o_addr(addr), .o_am(am), .o_as_n(as_n), .o_ds0_n(ds0_n), .o_ds1_n(ds1_n),
    .o_write_n(write_n), .o_lword_n(lword_n), .o_data(wdat));
  // Undriven data lines read as the inverse, so a missing drive cannot pass.
  assign bus_d = oe ? rdat : ~rdat;
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic io(input logic [23:0] adr, input logic wr, input logic [7:0] wd,
                    input logic [7:0] exp, input logic eack);
    ccr_bm_inst.acc(adr, wr, ccr_pkg::AM_CSR, wd, rd, ack);
    chk({7'h00, eack}, {7'h00, ack});
    if (!wr && eack)
      chk(exp, rd);
  endtask
  task automatic t_reset_vals;
    io({5'h01, ccr_pkg::OFS_BAR}, 1'b0, 8'h00, 8'h08, 1'b1);
    io({5'h01, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask
  task automatic t_set;
    io({5'h01, ccr_pkg::OFS_SET}, 1'b1, 8'hE0, 8'h00, 1'b1);
    io({5'h01, ccr_pkg::OFS_SET}, 1'b1, 8'h00, 8'h00, 1'b1);
    io({5'h01, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'hC0, 1'b1);
    io({5'h01, ccr_pkg::OFS_CLR}, 1'b0, 8'h00, 8'hC0, 1'b1);
    chk(8'h03, {6'h00, rm, sfe});
    chk(8'h00, {6'h00, dt_n, sf_n});
  endtask
  task automatic t_fail;
    @(negedge i_sys_clk);
    i_board_failed = 1'b1;
    io({5'h01, ccr_pkg::OFS_CLR}, 1'b1, 8'h20, 8'h00, 1'b1);
    io({5'h01, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'hE0, 1'b1);
    chk(8'h01, {7'h00, sf_oe});
    io({5'h01, ccr_pkg::OFS_CLR}, 1'b1, 8'h40, 8'h00, 1'b1);
    io({5'h01, ccr_pkg::OFS_CLR}, 1'b0, 8'h00, 8'hA0, 1'b1);
    chk(8'h00, {7'h00, sf_oe});
    io({5'h01, ccr_pkg::OFS_CLR}, 1'b1, 8'h80, 8'h00, 1'b1);
    io({5'h01, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'h20, 1'b1);
    i_board_failed = 1'b0;
  endtask
  task automatic t_rsvd;
    io({5'h01, 19'h7FFF3}, 1'b1, 8'hFF, 8'h00, 1'b1);
    io({5'h01, 19'h7FFF3}, 1'b0, 8'h00, 8'h00, 1'b1);
    io({5'h01, 19'h7FFFE}, 1'b0, 8'h00, 8'h00, 1'b1);
    io({5'h01, 19'h7FFEF}, 1'b0, 8'h00, 8'h00, 1'b0);
    ccr_bm_inst.acc({5'h01, ccr_pkg::OFS_SET}, 1'b0, 6'h3D, 8'h00, rd, ack);
    chk(8'h00, {7'h00, ack});
  endtask
  task automatic t_region;
    io({5'h01, ccr_pkg::OFS_BAR}, 1'b1, 8'h11, 8'h00, 1'b1);
    chk(8'h11, sel);
    io({5'h01, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'h00, 1'b0);
    io({5'h00, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'h00, 1'b0);
    io({5'h02, ccr_pkg::OFS_BAR}, 1'b0, 8'h00, 8'h11, 1'b1);
    io({5'h02, ccr_pkg::OFS_BAR}, 1'b1, 8'hF8, 8'h00, 1'b1);
    io({5'h1F, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask
  // A zero region-select must silence region zero; only a reset brings it back.
  task automatic t_zero;
    io({5'h1F, ccr_pkg::OFS_BAR}, 1'b1, 8'h00, 8'h00, 1'b1);
    io({5'h00, ccr_pkg::OFS_SET}, 1'b0, 8'h00, 8'h00, 1'b0);
    @(negedge i_sys_clk);
    i_rst_n = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    io({5'h01, ccr_pkg::OFS_BAR}, 1'b0, 8'h00, 8'h08, 1'b1);
    io({5'h01, ccr_pkg::OFS_CLR}, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Twenty-seven accesses of at most about twenty cycles each fit well inside this span.
  initial
  begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    i_rst_n = 1'b0;
    i_board_failed = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    t_reset_vals();
    t_set();
    t_fail();
    t_rsvd();
    t_region();
    t_zero();
    complete_run();
  end
endmodule // tb_top
